// *** rtl/timer16_regs.sv ***
// Register side of the 16-bit timer: count, capture, compares, mask and flags
`timescale 1ns/1ps
module timer16_regs
  import timer16_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic timer_tick,
  input wire logic capture_input_pin,
  input wire logic comparator_out,
  input wire logic capture_src_comparator,
  input wire logic capture_rising,
  input wire logic capture_is_top,
  input wire logic global_irq_enable,
  input wire logic [3:0] vector_ack,
  output logic [15:0] running_count_value,
  output logic [15:0] top_value,
  output logic match_a,
  output logic match_b,
  output logic waveform_out_a,
  output logic waveform_out_b,
  output logic [3:0] irq_req
);
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] capture;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [7:0] mask;
    logic [7:0] flags;
    logic [7:0] temp;
    logic [7:0] rdata;
    logic block;
    logic src_prev;
    logic wave_a;
    logic wave_b;
  } state_type;
  state_type s_q, s_d;
  logic set_a, set_b, m_a, m_b, src, cap_evt, at_top, wr_cnt;
  logic [7:0] base, flag_set;
  logic hi;

  assign hi = cpu_addr[0];
  assign base = cpu_addr & ~HIGH_BYTE_OFFSET;
  assign wr_cnt = cpu_wr && !hi && (base == ADDR_COUNT);
  assign src = capture_src_comparator ? comparator_out : capture_input_pin;
  assign cap_evt = !capture_is_top && (src != s_q.src_prev) && (src == capture_rising);
  assign top_value = capture_is_top ? s_q.capture : COUNT_MAX;
  assign at_top = timer_tick && (s_q.count == top_value);

  compare_unit u_cmp_a (
    .sys_clk(sys_clk), .rst(rst), .tick(timer_tick), .block(s_q.block),
    .count(s_q.count), .compare(s_q.cmp_a), .match(m_a), .flag_set(set_a)
  );
  compare_unit u_cmp_b (
    .sys_clk(sys_clk), .rst(rst), .tick(timer_tick), .block(s_q.block),
    .count(s_q.count), .compare(s_q.cmp_b), .match(m_b), .flag_set(set_b)
  );

  always_comb begin
    s_d = s_q;
    flag_set = RESET_BYTE;
    flag_set[BIT_CMP_A] = set_a;
    flag_set[BIT_CMP_B] = set_b;
    flag_set[BIT_OVF] = at_top && !capture_is_top;
    flag_set[BIT_CAPTURE] = cap_evt || (at_top && capture_is_top);
    s_d.src_prev = src;
    if (timer_tick) begin
      s_d.block = 1'b0;
      s_d.count = at_top ? RESET_WORD : 16'(s_q.count + COUNT_ONE);
      if (m_a) s_d.wave_a = ~s_q.wave_a;
      if (m_b) s_d.wave_b = ~s_q.wave_b;
    end
    if (cap_evt) s_d.capture = s_q.count;
    // Vector or write-one clear, set wins
    s_d.flags = s_q.flags;
    s_d.flags[BIT_OVF] = s_q.flags[BIT_OVF] & ~vector_ack[0];
    s_d.flags[BIT_CMP_A] = s_q.flags[BIT_CMP_A] & ~vector_ack[1];
    s_d.flags[BIT_CMP_B] = s_q.flags[BIT_CMP_B] & ~vector_ack[2];
    s_d.flags[BIT_CAPTURE] = s_q.flags[BIT_CAPTURE] & ~vector_ack[3];
    if (cpu_wr && cpu_addr == ADDR_FLAG) s_d.flags = s_d.flags & ~(cpu_wdata & MASK_BITS);
    if (cpu_wr) begin
      if (cpu_addr == ADDR_MASK) s_d.mask = cpu_wdata & MASK_BITS;
      if (hi && (base == ADDR_COUNT || base == ADDR_CAPTURE || base == ADDR_CMP_A ||
          base == ADDR_CMP_B)) s_d.temp = cpu_wdata;
      if (!hi) begin
        case (base)
          ADDR_COUNT: begin
            s_d.count = {s_q.temp, cpu_wdata};
            s_d.block = 1'b1;
          end
          ADDR_CAPTURE: s_d.capture = {s_q.temp, cpu_wdata};
          ADDR_CMP_A: s_d.cmp_a = {s_q.temp, cpu_wdata};
          ADDR_CMP_B: s_d.cmp_b = {s_q.temp, cpu_wdata};
          default: ;
        endcase
      end
    end
    s_d.flags = s_d.flags | flag_set;
    s_d.rdata = RESET_BYTE;
    if (cpu_rd) begin
      if (!hi) begin
        case (base)
          ADDR_COUNT: begin
            s_d.rdata = s_q.count[7:0];
            s_d.temp = s_q.count[15:8];
          end
          ADDR_CAPTURE: begin
            s_d.rdata = s_q.capture[7:0];
            s_d.temp = s_q.capture[15:8];
          end
          ADDR_CMP_A: begin
            s_d.rdata = s_q.cmp_a[7:0];
            s_d.temp = s_q.cmp_a[15:8];
          end
          ADDR_CMP_B: begin
            s_d.rdata = s_q.cmp_b[7:0];
            s_d.temp = s_q.cmp_b[15:8];
          end
          default: begin
            if (cpu_addr == ADDR_MASK) s_d.rdata = s_q.mask;
            else if (cpu_addr == ADDR_FLAG) s_d.rdata = s_q.flags;
          end
        endcase
      end else if (base == ADDR_COUNT || base == ADDR_CAPTURE || base == ADDR_CMP_A ||
          base == ADDR_CMP_B) begin
        s_d.rdata = s_q.temp;
      end else if (cpu_addr == ADDR_MASK) begin
        s_d.rdata = s_q.mask;
      end else if (cpu_addr == ADDR_FLAG) begin
        s_d.rdata = s_q.flags;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cpu_rdata = s_q.rdata;
  assign running_count_value = s_q.count;
  assign match_a = m_a;
  assign match_b = m_b;
  assign waveform_out_a = s_q.wave_a;
  assign waveform_out_b = s_q.wave_b;
  assign irq_req[3] = global_irq_enable && s_q.mask[BIT_CAPTURE] && s_q.flags[BIT_CAPTURE];
  assign irq_req[2] = global_irq_enable && s_q.mask[BIT_CMP_B] && s_q.flags[BIT_CMP_B];
  assign irq_req[1] = global_irq_enable && s_q.mask[BIT_CMP_A] && s_q.flags[BIT_CMP_A];
  assign irq_req[0] = global_irq_enable && s_q.mask[BIT_OVF] && s_q.flags[BIT_OVF];

  AST_IRQ_A: assert property (@(posedge sys_clk) disable iff (rst)
    irq_req[1] == (global_irq_enable && s_q.mask[BIT_CMP_A] && s_q.flags[BIT_CMP_A]))
    else $error("compare A interrupt wrong");

  AST_IRQ_B: assert property (@(posedge sys_clk) disable iff (rst)
    irq_req[2] == (global_irq_enable && s_q.mask[BIT_CMP_B] && s_q.flags[BIT_CMP_B]))
    else $error("compare B interrupt wrong");

  AST_IRQ_CAP: assert property (@(posedge sys_clk) disable iff (rst)
    irq_req[3] == (global_irq_enable && s_q.mask[BIT_CAPTURE] && s_q.flags[BIT_CAPTURE]))
    else $error("capture interrupt wrong");

  AST_IRQ_OVF: assert property (@(posedge sys_clk) disable iff (rst)
    irq_req[0] == (global_irq_enable && s_q.mask[BIT_OVF] && s_q.flags[BIT_OVF]))
    else $error("overflow interrupt wrong");

  AST_FLAG_A: assert property (@(posedge sys_clk) disable iff (rst)
    set_a |=> s_q.flags[BIT_CMP_A]) else $error("compare A flag not set");

  AST_FLAG_B: assert property (@(posedge sys_clk) disable iff (rst)
    set_b |=> s_q.flags[BIT_CMP_B]) else $error("compare B flag not set");

  // Match at tick raises set pulse
  AST_HIT_A: assert property (@(posedge sys_clk) disable iff (rst)
    (timer_tick && match_a) |=> set_a) else $error("compare A hit lost");

  // No match right after count write
  AST_BLOCK: assert property (@(posedge sys_clk) disable iff (rst)
    wr_cnt |=> !match_a && !match_b) else $error("match not blocked");

  AST_NO_HIT: assert property (@(posedge sys_clk) disable iff (rst)
    (timer_tick && s_q.block) |=> !set_a && !set_b) else $error("blocked match flagged");

  AST_CNT_WR: assert property (@(posedge sys_clk) disable iff (rst)
    wr_cnt |=> running_count_value == {$past(s_q.temp), $past(cpu_wdata)})
    else $error("count write lost");

  AST_TICK_INC: assert property (@(posedge sys_clk) disable iff (rst)
    (timer_tick && !at_top && !wr_cnt) |=>
    running_count_value == $past(running_count_value) + COUNT_ONE)
    else $error("count did not step");

  AST_WRAP: assert property (@(posedge sys_clk) disable iff (rst)
    (at_top && !capture_is_top && !wr_cnt) |=>
    running_count_value == RESET_WORD && s_q.flags[BIT_OVF])
    else $error("overflow not flagged");

  AST_TOP_CAP: assert property (@(posedge sys_clk) disable iff (rst)
    (at_top && capture_is_top) |=> s_q.flags[BIT_CAPTURE])
    else $error("capture flag not set at top");

  AST_TOP_SEL: assert property (@(posedge sys_clk) disable iff (rst)
    capture_is_top |-> top_value == s_q.capture) else $error("top not from capture");

  AST_CAPTURE: assert property (@(posedge sys_clk) disable iff (rst)
    cap_evt |=> s_q.capture == $past(s_q.count) && s_q.flags[BIT_CAPTURE])
    else $error("capture wrong");

  AST_TEMP: assert property (@(posedge sys_clk) disable iff (rst)
    (cpu_rd && cpu_addr == ADDR_CMP_B) |=> s_q.temp == $past(s_q.cmp_b[15:8]))
    else $error("latch not loaded");

  // High write lands in shared latch
  AST_WR_LATCH: assert property (@(posedge sys_clk) disable iff (rst)
    (cpu_wr && !cpu_rd && cpu_addr == ADDR_CMP_A + HIGH_BYTE_OFFSET) |=>
    s_q.temp == $past(cpu_wdata)) else $error("high byte not latched");

  AST_CMP_WR: assert property (@(posedge sys_clk) disable iff (rst)
    (cpu_wr && cpu_addr == ADDR_CMP_A) |=> s_q.cmp_a == {$past(s_q.temp), $past(cpu_wdata)})
    else $error("compare A write lost");

  // Low byte read at base offset
  AST_RD_LOW: assert property (@(posedge sys_clk) disable iff (rst)
    (cpu_rd && cpu_addr == ADDR_COUNT) |=> cpu_rdata == $past(s_q.count[7:0]))
    else $error("low byte read wrong");

  AST_RD_HIGH: assert property (@(posedge sys_clk) disable iff (rst)
    (cpu_rd && cpu_addr == ADDR_COUNT + HIGH_BYTE_OFFSET) |=> cpu_rdata == $past(s_q.temp))
    else $error("high byte read wrong");

  AST_RD_IDLE: assert property (@(posedge sys_clk) disable iff (rst)
    !cpu_rd |=> cpu_rdata == RESET_BYTE) else $error("read data not idle");

  AST_CLR: assert property (@(posedge sys_clk) disable iff (rst)
    (cpu_wr && cpu_addr == ADDR_FLAG && cpu_wdata[BIT_OVF] && !flag_set[BIT_OVF]) |=>
    !s_q.flags[BIT_OVF]) else $error("flag not cleared");

  AST_VEC_A: assert property (@(posedge sys_clk) disable iff (rst)
    (vector_ack[BIT_CMP_A] && !set_a) |=> !s_q.flags[BIT_CMP_A])
    else $error("vector did not clear flag");

  AST_WAVE_A: assert property (@(posedge sys_clk) disable iff (rst)
    (timer_tick && match_a) |=> waveform_out_a != $past(waveform_out_a))
    else $error("waveform A not toggled");

  AST_MASK: assert property (@(posedge sys_clk) disable iff (rst)
    (s_q.mask & ~MASK_BITS) == RESET_BYTE) else $error("reserved mask bit set");
endmodule

// *** rtl/timer16_pkg.sv ***
// Constants shared by the 16-bit timer register block
package timer16_pkg;
  localparam logic [7:0] ADDR_MASK = 8'h6f;
  localparam logic [7:0] ADDR_FLAG = 8'h36;
  localparam logic [7:0] ADDR_COUNT = 8'h84;
  localparam logic [7:0] ADDR_CAPTURE = 8'h86;
  localparam logic [7:0] ADDR_CMP_A = 8'h88;
  localparam logic [7:0] ADDR_CMP_B = 8'h8a;
  localparam logic [7:0] HIGH_BYTE_OFFSET = 8'h01;
  localparam int BIT_OVF = 0;
  localparam int BIT_CMP_A = 1;
  localparam int BIT_CMP_B = 2;
  localparam int BIT_CAPTURE = 5;
  localparam logic [7:0] MASK_BITS = 8'h27;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
endpackage

// *** rtl/compare_unit.sv ***
// One compare channel: match detect and flag pulse one clock cycle after the matching tick
`timescale 1ns/1ps
module compare_unit
  import timer16_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic block,
  input wire logic [15:0] count,
  input wire logic [15:0] compare,
  output logic match,
  output logic flag_set
);
  typedef struct packed {
    logic hit;
  } state_type;
  state_type s_q, s_d;
  always_comb begin
    s_d = s_q;
    // Match at tick edge, flag next cycle
    s_d.hit = tick && (count == compare) && !block;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign match = (count == compare) && !block;
  assign flag_set = s_q.hit;
endmodule

// *** dv/testbench.sv ***
// Self-checking bench for the 16-bit timer register block
`timescale 1ns/1ps
module testbench;
  import timer16_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] cpu_addr = 8'h00;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] cpu_rdata;
  logic timer_tick = 1'b0;
  logic capture_input_pin = 1'b0;
  logic comparator_out = 1'b0;
  logic capture_src_comparator = 1'b0;
  logic capture_rising = 1'b1;
  logic capture_is_top = 1'b0;
  logic global_irq_enable = 1'b0;
  logic [3:0] vector_ack = 4'h0;
  logic [15:0] running_count_value;
  logic [15:0] top_value;
  logic match_a;
  logic match_b;
  logic waveform_out_a;
  logic waveform_out_b;
  logic [3:0] irq_req;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;

  timer16_regs i_timer16_regs (.sys_clk(sys_clk), .rst(rst), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .timer_tick(timer_tick), .capture_input_pin(capture_input_pin),
    .comparator_out(comparator_out), .capture_src_comparator(capture_src_comparator),
    .capture_rising(capture_rising), .capture_is_top(capture_is_top),
    .global_irq_enable(global_irq_enable), .vector_ack(vector_ack),
    .running_count_value(running_count_value), .top_value(top_value),
    .match_a(match_a), .match_b(match_b), .waveform_out_a(waveform_out_a),
    .waveform_out_b(waveform_out_b),
    .irq_req(irq_req));

  always #2.5 sys_clk = ~sys_clk;

  task automatic end_sim();
    if (bad_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count = bad_count + 1;
      $display("[ERR] %0t timeout", $time);
      end_sim();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge sys_clk);
    cpu_wr = 1'b0;
  endtask

  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge sys_clk);
    cpu_rd = 1'b0;
    d = cpu_rdata;
  endtask

  task automatic chk_rd8(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd8(a, d);
    chk8(d, exp);
  endtask

  // High byte first, low byte commits
  task automatic wr16(input logic [7:0] base, input logic [15:0] v);
    wr8(base + HIGH_BYTE_OFFSET, v[15:8]);
    wr8(base, v[7:0]);
  endtask

  // Low byte first loads the latch
  task automatic chk_rd16(input logic [7:0] base, input logic [15:0] exp);
    chk_rd8(base, exp[7:0]);
    chk_rd8(base + HIGH_BYTE_OFFSET, exp[15:8]);
  endtask

  task automatic tick();
    @(negedge sys_clk);
    timer_tick = 1'b1;
    @(negedge sys_clk);
    timer_tick = 1'b0;
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    chk_rd8(ADDR_MASK, 8'h00);
    chk_rd16(ADDR_COUNT, 16'h0000);
    chk_rd16(ADDR_CAPTURE, 16'h0000);
    chk_rd16(ADDR_CMP_A, 16'h0000);
    chk_rd16(ADDR_CMP_B, 16'h0000);
    wr16(ADDR_COUNT, 16'h1234);
    chk_rd16(ADDR_COUNT, 16'h1234);
    wr16(ADDR_CMP_A, 16'h0010);
    chk_rd16(ADDR_CMP_A, 16'h0010);
    wr16(ADDR_CAPTURE, 16'h9a0b);
    chk_rd16(ADDR_CAPTURE, 16'h9a0b);
    wr8(ADDR_CMP_A + HIGH_BYTE_OFFSET, 8'h56);
    wr8(ADDR_CMP_B, 8'h78);
    chk_rd16(ADDR_CMP_B, 16'h5678);
    chk_rd16(ADDR_CMP_A, 16'h0010);
    wr8(ADDR_MASK, 8'hff);
    chk_rd8(ADDR_MASK, MASK_BITS);
    chk_rd8(8'h70, 8'h00);
    global_irq_enable = 1'b1;
    wr16(ADDR_COUNT, 16'h0abc);
    @(negedge sys_clk);
    capture_input_pin = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk_rd16(ADDR_CAPTURE, 16'h0abc);
    chk8({4'h0, irq_req}, 8'h08);
    wr8(ADDR_FLAG, 8'h20);
    chk_rd8(ADDR_FLAG, 8'h00);
    capture_src_comparator = 1'b1;
    wr16(ADDR_COUNT, 16'h0bcd);
    @(negedge sys_clk);
    comparator_out = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk_rd16(ADDR_CAPTURE, 16'h0bcd);
    // Falling edge select
    capture_rising = 1'b0;
    wr16(ADDR_COUNT, 16'h0cde);
    @(negedge sys_clk);
    comparator_out = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk_rd16(ADDR_CAPTURE, 16'h0cde);
    wr8(ADDR_FLAG, 8'h20);
    wr16(ADDR_COUNT, 16'h0010);
    chk8({7'h00, match_a}, 8'h00);
    tick();
    tick();
    chk_rd8(ADDR_FLAG, 8'h00);
    wr16(ADDR_COUNT, 16'h000f);
    tick();
    chk8({7'h00, match_a}, 8'h01);
    tick();
    repeat (2) @(negedge sys_clk);
    chk_rd8(ADDR_FLAG, 8'h02);
    chk8({4'h0, irq_req}, 8'h02);
    global_irq_enable = 1'b0;
    #1;
    chk8({4'h0, irq_req}, 8'h00);
    global_irq_enable = 1'b1;
    @(negedge sys_clk);
    vector_ack = 4'h2;
    @(negedge sys_clk);
    vector_ack = 4'h0;
    chk_rd8(ADDR_FLAG, 8'h00);
    wr16(ADDR_CMP_B, 16'h0005);
    wr16(ADDR_COUNT, 16'h0004);
    tick();
    tick();
    repeat (2) @(negedge sys_clk);
    chk8({4'h0, irq_req}, 8'h04);
    chk8({7'h00, waveform_out_a}, 8'h01);
    chk8({7'h00, waveform_out_b}, 8'h01);
    wr8(ADDR_FLAG, 8'h04);
    wr16(ADDR_COUNT, 16'hffff);
    tick();
    repeat (2) @(negedge sys_clk);
    chk_rd16(ADDR_COUNT, 16'h0000);
    chk8({4'h0, irq_req}, 8'h01);
    wr8(ADDR_FLAG, 8'h01);
    chk_rd8(ADDR_FLAG, 8'h00);
    capture_is_top = 1'b1;
    @(negedge sys_clk);
    chk8(top_value[15:8], 8'h0c);
    chk8(top_value[7:0], 8'hde);
    end_sim();
  end
endmodule
